// ### dv/tb_ilo_decode.sv
// Self-checking testbench for the indexed literal offset decode block.
`timescale 1ns/1ps
`include "ilo_params.svh"
module tb_ilo_decode;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        vld = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        en = 1'b1;
  logic        sp_we = 1'b0;
  logic [11:0] sp_wd = 12'h000;
  logic        bsr_we = 1'b0;
  logic [3:0]  bsr_wd = 4'h0;
  logic        dbg_re = 1'b0;
  logic [11:0] dbg_addr = 12'h000;
  logic        rdy, done, ill, idx;
  logic [7:0]  wreg;
  logic [4:0]  st;
  logic [11:0] spo, ea;
  int          err_total = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          mem[int];
  int          m_w = 0, m_st = 0, m_sp = 0, m_bsr = 0;

  ilo_decode dut_u (
    .I_CLK(clk), .I_RSTN(rstn), .I_INSTR_VALID(vld), .I_INSTR(instr),
    .I_EXTENDED_SET_ENABLE_BIT(en), .I_SP_WE(sp_we), .I_SP_WDATA(sp_wd),
    .I_BSR_WE(bsr_we), .I_BSR_WDATA(bsr_wd), .I_DBG_RE(dbg_re), .I_DBG_ADDR(dbg_addr),
    .O_READY(rdy), .O_DONE(done), .O_ILLEGAL(ill), .O_WREG(wreg), .O_STATUS(st),
    .O_STACK_POINTER_REG(spo), .O_EA(ea), .O_INDEXED(idx)
  );

  always #12.5 clk = ~clk;

  task automatic summarize();
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // The debug port only moves the memory read address; random traffic there must be harmless.
  always @(posedge clk) begin
    cycles++;
    dbg_re <= 1'($urandom);
    dbg_addr <= 12'($urandom);
    if (cycles > 6000) begin
      err_total++;
      summarize();
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [11:0] eff(input logic a, input logic [7:0] k);
    if (en && !a && k <= `ILO_OFS_MAX) return m_sp[11:0] + {4'h0, k};
    if (a) return {m_bsr[3:0], k};
    if (k >= 8'h80) return {4'hF, k};
    return {4'h0, k};
  endfunction : eff

  task automatic load(input logic [11:0] sp, input logic [3:0] bsr);
    @(posedge clk);
    sp_we <= 1'b1;
    sp_wd <= sp;
    bsr_we <= 1'b1;
    bsr_wd <= bsr;
    @(posedge clk);
    sp_we <= 1'b0;
    bsr_we <= 1'b0;
    m_sp = sp;
    m_bsr = bsr;
  endtask : load

  task automatic exec(input logic [15:0] ins, input bit legal);
    logic [11:0] a12;
    int          m;
    int          s;
    a12 = eff(ins[8], ins[7:0]);
    @(posedge clk);
    instr <= ins;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    // A pointer load while busy must be dropped.
    sp_we <= 1'b1;
    sp_wd <= ~m_sp[11:0];
    @(posedge clk);
    sp_we <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    if (ins[15:10] == `ILO_OPC_ADD) begin
      m = mem[a12];
      s = m_w + m;
      m_st = 0;
      m_st[`ILO_FLAG_C] = s > 255;
      m_st[`ILO_FLAG_DC] = (m_w % 16) + (m % 16) > 15;
      m_st[`ILO_FLAG_Z] = (s % 256) == 0;
      m_st[`ILO_FLAG_N] = s[7];
      m_st[`ILO_FLAG_OV] = (m_w[7] == m[7]) && (s[7] != m_w[7]);
      if (ins[9]) mem[a12] = s % 256;
      else m_w = s % 256;
    end else if (ins[15:12] == `ILO_OPC_BSF) mem[a12] = mem[a12] | (1 << ins[11:9]);
    else if (ins[15:9] == `ILO_OPC_SET_ALL_ONES_OP) mem[a12] = 255;
    chk(ill, !legal, "illegal");
    if (legal) begin
      chk(done, 1'b1, "done");
      chk(rdy, 1'b1, "ready");
      chk(ea, a12, "ea");
      chk(idx, en && !ins[8] && ins[7:0] <= `ILO_OFS_MAX, "indexed");
    end
    chk(wreg, m_w[7:0], "wreg");
    chk(st, m_st[4:0], "status");
    chk(spo, m_sp[11:0], "pointer");
  endtask : exec

  initial begin
    logic [7:0] k;
    logic       a;
    int         mode;
    void'($urandom(85));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk(wreg, 12'h000, "reset wreg");
    chk(st, 12'h000, "reset status");
    chk(spo, 12'h000, "reset pointer");
    chk(done, 12'h000, "reset done");
    for (int e = 1; e >= 0; e--) begin
      @(posedge clk);
      en <= 1'(e);
      for (int it = 0; it < 24; it++) begin
        mode = $urandom % 4;
        a = (mode == 3);
        k = (mode == 0) ? 8'($urandom % 96) : (mode == 1) ? 8'(8'h60 + $urandom % 32) :
            (mode == 2) ? 8'(8'h80 + $urandom % 128) : 8'($urandom);
        if (it == 0) k = `ILO_OFS_MAX;
        if (it == 0) a = 1'b0;
        if (it == 1) k = 8'h60;
        if (it == 1) a = 1'b0;
        load(12'($urandom), 4'($urandom));
        exec({`ILO_OPC_SET_ALL_ONES_OP, a, k}, 1'b1);
        exec({`ILO_OPC_ADD, 1'b1, a, k}, 1'b1);
        exec({`ILO_OPC_BSF, 3'($urandom), a, k}, 1'b1);
        exec({`ILO_OPC_ADD, 1'b0, a, k}, 1'b1);
      end
    end
    exec(16'hF000, 1'b0);
    summarize();
  end
endmodule : tb_ilo_decode

// ### rtl/ilo_decode.sv
// Indexed literal offset decode and execute for add, bit set and set-all-ones.
// Notes on behaviour
// - With extended set on, small access operands are offsets from the stack pointer.
// - Offset only when access bit is zero and operand at most 5Fh.
// - Indexed add sums working register and byte at pointer plus offset 0..95.
// - Destination bit zero writes working register; one writes the data byte.
// - Indexed add updates negative, overflow, carry, digit carry and zero.
// - Indexed bit set forces selected bit 0..7 to one; flags untouched.
// - Indexed set-all-ones writes FFh to the byte; flags untouched.
// - Enable bit zero disables offset addressing only; the three opcodes still execute.
`timescale 1ns/1ps
`include "ilo_params.svh"
module ilo_decode (
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_INSTR_VALID,
  input  wire logic [15:0] I_INSTR,
  input  wire logic        I_EXTENDED_SET_ENABLE_BIT,
  input  wire logic        I_SP_WE,
  input  wire logic [11:0] I_SP_WDATA,
  input  wire logic        I_BSR_WE,
  input  wire logic [3:0]  I_BSR_WDATA,
  input  wire logic        I_DBG_RE,
  input  wire logic [11:0] I_DBG_ADDR,
  output logic             O_READY,
  output logic             O_DONE,
  output logic             O_ILLEGAL,
  output logic [7:0]       O_WREG,
  output logic [4:0]       O_STATUS,
  output logic [11:0]      O_STACK_POINTER_REG,
  output logic [11:0]      O_EA,
  output logic             O_INDEXED
);
  ilo_pkg::ilo_phase_t phase;
  ilo_pkg::ilo_op_t    op;
  logic                busy;
  logic [15:0]         ir;
  logic [11:0]         ea;
  logic [7:0]          rdata;
  logic [7:0]          result;
  logic                dest_f;
  logic                mem_we;
  logic [3:0]          bsr;
  logic                ext_en;
  logic                indexed;
  logic [11:0]         next_ea;
  ilo_pkg::ilo_op_t    next_op;
  logic [8:0]          sum;
  logic [4:0]          lo_sum;
  logic                ovf;
  logic [11:0]         raddr;

  // The enable bit is a configuration fuse, treated as static during operation.
  assign ext_en = I_EXTENDED_SET_ENABLE_BIT;

  // Address generation from the raw instruction at Q1.
  always_comb begin
    indexed = 1'b0;
    next_ea = {4'h0, I_INSTR[7:0]};
    if (ext_en && !I_INSTR[8] && (I_INSTR[7:0] <= `ILO_OFS_MAX)) begin
      indexed = 1'b1;
      next_ea = O_STACK_POINTER_REG + {4'h0, I_INSTR[7:0]};
    end else if (I_INSTR[8]) begin
      next_ea = {bsr, I_INSTR[7:0]};
    end else if (I_INSTR[7]) begin
      next_ea = {4'hF, I_INSTR[7:0]};
    end
  end

  // Only the three covered opcodes are executed here; all others are flagged.
  always_comb begin
    next_op = ilo_pkg::ILO_OP_NONE;
    if (I_INSTR[15:10] == `ILO_OPC_ADD) begin
      next_op = ilo_pkg::ILO_OP_ADD;
    end else if (I_INSTR[15:12] == `ILO_OPC_BSF) begin
      next_op = ilo_pkg::ILO_OP_BSF;
    end else if (I_INSTR[15:9] == `ILO_OPC_SET_ALL_ONES_OP) begin
      next_op = ilo_pkg::ILO_OP_SET_ALL_ONES_OP;
    end
  end

  assign sum    = {1'b0, O_WREG} + {1'b0, rdata};
  assign lo_sum = {1'b0, O_WREG[3:0]} + {1'b0, rdata[3:0]};
  assign ovf    = (O_WREG[7] == rdata[7]) && (sum[7] != O_WREG[7]);
  // The operand byte is used at the Q3 edge, so the Q2 edge must re-read the latched address.
  // A debug read is let through only in Q3 and Q4, where it cannot disturb the operand.
  always_comb begin
    raddr = ea;
    if (phase == ilo_pkg::ILO_Q1) begin
      raddr = next_ea;
    end else if (phase != ilo_pkg::ILO_Q2 && I_DBG_RE) begin
      raddr = I_DBG_ADDR;
    end
  end

  ilo_dmem u_dmem (
    .i_clk   (I_CLK),
    .i_raddr (raddr),
    .o_rdata (rdata),
    .i_we    (mem_we),
    .i_waddr (ea),
    .i_wdata (result)
  );

  // Quarter-phase sequencer: Q1 decode, Q2 read, Q3 process, Q4 write.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      phase <= ilo_pkg::ILO_Q1;
      busy  <= 1'b0;
    end else begin
      case (phase)
        ilo_pkg::ILO_Q1: begin
          if (I_INSTR_VALID) begin
            phase <= ilo_pkg::ILO_Q2;
            busy  <= 1'b1;
          end
        end
        ilo_pkg::ILO_Q2: phase <= ilo_pkg::ILO_Q3;
        ilo_pkg::ILO_Q3: phase <= ilo_pkg::ILO_Q4;
        ilo_pkg::ILO_Q4: begin
          phase <= ilo_pkg::ILO_Q1;
          busy  <= 1'b0;
        end
        default: phase <= ilo_pkg::ILO_Q1;
      endcase
    end
  end

  // Latch of the decoded instruction.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      ir        <= 16'h0000;
      op        <= ilo_pkg::ILO_OP_NONE;
      ea        <= 12'h000;
      O_EA      <= 12'h000;
      O_INDEXED <= 1'b0;
      O_ILLEGAL <= 1'b0;
    end else if (phase == ilo_pkg::ILO_Q1 && I_INSTR_VALID) begin
      ir        <= I_INSTR;
      ea        <= next_ea;
      O_EA      <= next_ea;
      O_INDEXED <= indexed;
      // With the set disabled, indexed forms do not exist and operands stay literal.
      op        <= next_op;
      O_ILLEGAL <= (next_op == ilo_pkg::ILO_OP_NONE);
    end
  end

  // Processing in Q3, computed from the byte read during Q2.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      result <= 8'h00;
      dest_f <= 1'b0;
    end else if (phase == ilo_pkg::ILO_Q3) begin
      dest_f <= 1'b1;
      case (op)
        ilo_pkg::ILO_OP_ADD: begin
          result <= sum[7:0];
          dest_f <= ir[9];
        end
        ilo_pkg::ILO_OP_BSF: result <= rdata | (8'h01 << ir[11:9]);
        ilo_pkg::ILO_OP_SET_ALL_ONES_OP: result <= `ILO_ALL_ONES;
        default: begin
          result <= rdata;
          dest_f <= 1'b0;
        end
      endcase
    end
  end

  // Write-back at Q4.
  always_comb begin
    mem_we = (phase == ilo_pkg::ILO_Q4) && dest_f && (op != ilo_pkg::ILO_OP_NONE);
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_WREG <= `ILO_WREG_RST;
    end else if (phase == ilo_pkg::ILO_Q4 && op == ilo_pkg::ILO_OP_ADD && !dest_f) begin
      O_WREG <= result;
    end
  end

  // Flags are captured in Q3 only for the add; bit set and set-all-ones leave them.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_STATUS <= `ILO_STATUS_RST;
    end else if (phase == ilo_pkg::ILO_Q3 && op == ilo_pkg::ILO_OP_ADD) begin
      O_STATUS[`ILO_FLAG_N]  <= sum[7];
      O_STATUS[`ILO_FLAG_OV] <= ovf;
      O_STATUS[`ILO_FLAG_Z]  <= (sum[7:0] == 8'h00);
      O_STATUS[`ILO_FLAG_DC] <= lo_sum[4];
      O_STATUS[`ILO_FLAG_C]  <= sum[8];
    end
  end

  // Pointer and bank are loaded by the rest of the core between instructions.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_STACK_POINTER_REG <= `ILO_SP_RST;
      bsr                 <= `ILO_BSR_RST;
    end else if (!busy) begin
      if (I_SP_WE) begin
        O_STACK_POINTER_REG <= I_SP_WDATA;
      end
      if (I_BSR_WE) begin
        bsr <= I_BSR_WDATA;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_DONE  <= 1'b0;
      O_READY <= 1'b0;
    end else begin
      O_DONE  <= (phase == ilo_pkg::ILO_Q4);
      O_READY <= (phase == ilo_pkg::ILO_Q4) || (phase == ilo_pkg::ILO_Q1 && !I_INSTR_VALID);
    end
  end

  a_indexed_addr: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (phase == ilo_pkg::ILO_Q1 && I_INSTR_VALID && ext_en && !I_INSTR[8]
     && I_INSTR[7:0] <= 8'h5F) |=> (O_EA == $past(O_STACK_POINTER_REG)
     + {4'h0, $past(I_INSTR[7:0])}))
    else $error("indexed address not pointer plus offset");

  a_literal_addr: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (phase == ilo_pkg::ILO_Q1 && I_INSTR_VALID && (I_INSTR[8] || I_INSTR[7:0] > 8'h5F))
    |=> !O_INDEXED)
    else $error("literal operand used as offset");

  a_disabled_mode: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (phase == ilo_pkg::ILO_Q1 && I_INSTR_VALID && !ext_en) |=> !O_INDEXED)
    else $error("offset mode active while disabled");

  a_one_cycle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (phase == ilo_pkg::ILO_Q1 && I_INSTR_VALID) |-> ##4 O_DONE)
    else $error("instruction did not finish in four phases");

  a_add_wreg: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (phase == ilo_pkg::ILO_Q4 && op == ilo_pkg::ILO_OP_ADD && !ir[9])
    |=> O_WREG == $past(result))
    else $error("add result not placed in working register");

  a_add_file: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (phase == ilo_pkg::ILO_Q4 && op == ilo_pkg::ILO_OP_ADD && ir[9])
    |-> mem_we ##1 $stable(O_WREG))
    else $error("add result not written to data byte");

  a_flags_kept: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (op != ilo_pkg::ILO_OP_ADD && phase != ilo_pkg::ILO_Q1) |=> $stable(O_STATUS))
    else $error("flags changed by bit set or set-all-ones");

  a_set_all_ones_op_value: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (phase == ilo_pkg::ILO_Q4 && op == ilo_pkg::ILO_OP_SET_ALL_ONES_OP) |-> mem_we && result == 8'hFF)
    else $error("set-all-ones wrote wrong value");

  a_bsf_bit: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (phase == ilo_pkg::ILO_Q4 && op == ilo_pkg::ILO_OP_BSF)
    |-> result == ($past(rdata) | (8'h01 << ir[11:9])))
    else $error("bit set result wrong");

  a_zero_flag: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (phase == ilo_pkg::ILO_Q3 && op == ilo_pkg::ILO_OP_ADD)
    |=> O_STATUS[2] == (result == 8'h00) && O_STATUS[0] == $past(sum[8]))
    else $error("add flags wrong");
endmodule : ilo_decode

// ### rtl/ilo_dmem.sv
// Data memory: 4096 bytes, registered read, one write port.
`timescale 1ns/1ps
module ilo_dmem (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_raddr,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_we,
  input  wire logic [11:0] i_waddr,
  input  wire logic [7:0]  i_wdata
);
  logic [7:0] mem [0:4095];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule : ilo_dmem

// ### rtl/ilo_params.svh
// Constants for the indexed literal offset decode block.
`ifndef ILO_PARAMS_SVH
`define ILO_PARAMS_SVH
`define ILO_OFS_MAX       8'h5F
`define ILO_OPC_ADD       6'h09
`define ILO_OPC_BSF       4'h8
`define ILO_OPC_SET_ALL_ONES_OP      7'h34
`define ILO_ALL_ONES      8'hFF
`define ILO_FLAG_N        4
`define ILO_FLAG_OV       3
`define ILO_FLAG_Z        2
`define ILO_FLAG_DC       1
`define ILO_FLAG_C        0
`define ILO_STATUS_RST    5'h00
`define ILO_WREG_RST      8'h00
`define ILO_SP_RST        12'h000
`define ILO_BSR_RST       4'h0
`endif

// ### rtl/ilo_pkg.sv
// Types for the indexed literal offset decode block.
package ilo_pkg;
  typedef enum logic [1:0] {
    ILO_OP_NONE,
    ILO_OP_ADD,
    ILO_OP_BSF,
    ILO_OP_SET_ALL_ONES_OP
  } ilo_op_t;
  typedef enum logic [1:0] {
    ILO_Q1,
    ILO_Q2,
    ILO_Q3,
    ILO_Q4
  } ilo_phase_t;
endpackage : ilo_pkg
